/* File: hdl/cbsc_regs.vh */
// Constants for the boot configuration chain: chain size, field positions,
// register offsets and reset values. Included by cbsc_evict_accum, cbsc_config_chain and the testbench.
`ifndef CBSC_REGS_VH
`define CBSC_REGS_VH
`define CBSC_CHAIN_LEN      367
`define CBSC_CHAIN_USED     304
`define CBSC_CHAIN_LAST     9'h16E
`define CBSC_IMG_W          44
`define CBSC_POS_IO32       0
`define CBSC_POS_RATIO      1
`define CBSC_POS_SKEW       2
`define CBSC_POS_THR        3
`define CBSC_POS_CLEAN      11
`define CBSC_POS_ASIZE      12
`define CBSC_POS_FMT        14
`define CBSC_POS_SCLK       15
`define CBSC_POS_DTAG       19
`define CBSC_POS_PTAG       20
`define CBSC_POS_FDIS       21
`define CBSC_POS_RVIC       22
`define CBSC_POS_CLEAN2     23
`define CBSC_POS_RVHOLD     24
`define CBSC_POS_MB         25
`define CBSC_POS_ACKL       26
`define CBSC_POS_VICL       31
`define CBSC_POS_CLEAN3     34
`define CBSC_POS_WWG        35
`define CBSC_POS_RWG        36
`define CBSC_POS_RRG        42
`define CBSC_POS_BANK       43
`define CBSC_MAX_VICTIMS    3'h6
`define CBSC_OFF_STATUS     12'h000
`define CBSC_OFF_CFG_LO     12'h004
`define CBSC_OFF_CFG_HI     12'h008
`define CBSC_OFF_CTRL       12'h00C
`define CBSC_CTRL_RST       2'h0
`define CBSC_CTRL_FLUSH     0
`define CBSC_CTRL_HOLD      1
`endif

/* File: hdl/cbsc_evict_accum.v */
// Data-cache victim accumulator that starts a streamed write burst.
// Assumes one victim offered per cycle at most; threshold is stable.
`timescale 1ns/1ps
`include "cbsc_regs.vh"
module cbsc_evict_accum (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       victim_push,
	input  wire       victim_clean,
	input  wire       clean_out_en,
	input  wire [7:0] threshold,
	input  wire       flush,
	output reg        stream_start,
	output reg        evict_full,
	output reg  [2:0] victim_count
);
	reg       accept;
	reg [2:0] count_nxt;
	reg       fire;

	always @* begin
		// Clean victims are dropped unless they are sent out as well.
		accept = victim_push & (~victim_clean | clean_out_en) & //RULE10
			(victim_count != `CBSC_MAX_VICTIMS); //RULE9
		count_nxt = victim_count + {2'h0, accept};
		// Threshold is decoded: bit n set starts the stream at n victims.
		fire = (count_nxt != 3'h0) & (threshold[count_nxt] | flush); //RULE9
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			victim_count <= 3'h0;
			stream_start <= 1'b0;
			evict_full   <= 1'b0;
		end else begin
			victim_count <= fire ? 3'h0 : count_nxt;
			stream_start <= fire;
			evict_full   <= ~fire & (count_nxt == `CBSC_MAX_VICTIMS);
		end
	end
endmodule

/* File: hdl/cbsc_gap_timer.v */
// Board-cache access spacer: inserts idle cycles between reads and writes.
// Assumes requests are held until granted; a read wins over a write.
`timescale 1ns/1ps
module cbsc_gap_timer (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       rd_req,
	input  wire       wr_req,
	input  wire       hold,
	input  wire       ww_gap,
	input  wire [5:0] rw_gap,
	input  wire       rr_gap,
	input  wire       bank_en,
	output reg        rd_go,
	output reg        wr_go
);
	reg [5:0] idle_r;
	reg       last_rd_r;
	reg [5:0] need_rd;
	reg [5:0] need_wr;
	reg       rd_fire;
	reg       wr_fire;

	always @* begin
		need_rd = {5'h00, last_rd_r & bank_en & rr_gap}; //RULE19 //RULE20
		need_wr = last_rd_r ? rw_gap : {5'h00, ww_gap}; //RULE17 //RULE18
		// A request is still seen at the edge that shows its grant; a standing grant
		// blocks its own kind so that one held request yields only one access.
		rd_fire = rd_req & ~hold & ~rd_go & (idle_r >= need_rd);
		wr_fire = wr_req & ~hold & ~wr_go & ~rd_fire & ~rd_req & (idle_r >= need_wr);
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idle_r    <= 6'h3F;
			last_rd_r <= 1'b0;
			rd_go     <= 1'b0;
			wr_go     <= 1'b0;
		end else begin
			rd_go <= rd_fire;
			wr_go <= wr_fire;
			if (rd_fire | wr_fire) begin
				idle_r    <= 6'h00;
				last_rd_r <= rd_fire;
			end else if (idle_r != 6'h3F) begin
				idle_r <= idle_r + 6'h01;
			end
		end
	end
endmodule

/* File: hdl/cbsc_config_chain.v */
// Boot configuration chain for the cache and system-bus unit, with APB access.
// Assumes the serial boot ROM presents bits synchronous to mclk after self-test.
//
// Behaviour
// RULE1: 367 bits shift in after self-test, first bit ends highest; extras spill out (the code takes no bits after the 367th).
// RULE2: only the low 304 positions matter; the rest are ignored.
// RULE3: the loader writes duplicate fields equal to their originals.
// RULE4: multibit fields keep their least significant bit at the lowest position.
// RULE5: fields start: 32-byte I/O, ratio bit, offset fill, eight-bit threshold.
// RULE6: the 32-byte I/O bit puts I/O transfers in 32-byte mode.
// RULE7: the loader sets the ratio bit only for the 1.5x board-cache ratio.
// RULE8: offset fill is required at 1.5x and optional at 3.0x or 3.5x.
// RULE9: up to six victims gather until the decoded threshold, then stream.
// RULE10: clean evictions go out as well when enabled.
// RULE11: two bits pick address bus width, one bit picks bus layout.
// RULE12: system clock multiplier is one-hot: 1.5X, 2.0X, 2.5X, 3.0X.
// RULE13: separate bits enable shadow-tag mode and snoop-tag-only mode.
// RULE14: a set disable bit stops fast data movement.
// RULE15: a set bit enables read-evict commands on the pins.
// RULE16: a set hold bit keeps read-evict commands off the acknowledge counter.
// RULE17: one bit gives idle cycles between back-to-back board-cache writes.
// RULE18: six bits give idle cycles when turning from read to write.
// RULE19: one bit adds an idle cycle between reads on banked caches.
// RULE20: the bank enable puts the board cache in banked mode.
// RULE21: after loading, settings stay fixed until the next reset.
// RULE22: barrier forwarding, acknowledge limit and victim limit drive bus logic.
`timescale 1ns/1ps
`include "cbsc_regs.vh"
module cbsc_config_chain (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        selftest_done,
	input  wire        boot_bit_valid,
	input  wire        boot_bit,
	output reg         chain_spill,
	output reg         chain_spill_valid,
	output reg         config_ready,
	input  wire        victim_push,
	input  wire        victim_clean,
	output wire        evict_stream_start,
	output wire        evict_full,
	input  wire        bc_rd_req,
	input  wire        bc_wr_req,
	output wire        bc_rd_go,
	output wire        bc_wr_go,
	input  wire        sys_cmd_issue,
	input  wire        sys_cmd_read_evict,
	input  wire        sys_ack_in,
	output reg         sys_cmd_stall,
	input  wire        mb_req,
	output reg         mb_forward,
	output reg         mb_local_done,
	output wire        io32_mode_en,
	output wire        ext_cache_ratio_bit,
	output wire        offset_fill_en,
	output wire        clean_evict_out_en,
	output wire [1:0]  sys_addr_width_sel,
	output wire        sys_bus_layout_sel,
	output wire [3:0]  sys_clock_multiplier,
	output wire        shadow_tag_en,
	output wire        snoop_tag_only_en,
	output wire        fast_move_dis,
	output wire        read_evict_cmd_en,
	output wire        cache_bank_mode_en,
	output wire [2:0]  sys_evict_ceiling
);
	reg [`CBSC_CHAIN_LEN-1:0] chain_r;
	reg [`CBSC_CHAIN_LEN-1:0] chain_nxt;
	reg [8:0]                 bit_cnt_r;
	reg [`CBSC_IMG_W-1:0]     cfg_r;
	reg                       dup_bad_r;
	reg                       clk_bad_r;
	reg [1:0]                 ctrl_r;
	reg                       flush_r;
	reg [4:0]                 outst_r;
	reg [4:0]                 outst_nxt;
	reg                       shift;
	reg                       cnt_inc;
	reg                       wr_acc;
	reg                       rd_setup;
	reg                       hit;
	reg [31:0]                rd_val;
	wire [2:0]                victim_count;

	wire [7:0] thr      = cfg_r[`CBSC_POS_THR +: 8]; //RULE4 //RULE5
	wire [4:0] ack_lim  = cfg_r[`CBSC_POS_ACKL +: 5]; //RULE22
	wire       rv_hold  = cfg_r[`CBSC_POS_RVHOLD];
	wire       mb_en    = cfg_r[`CBSC_POS_MB];
	wire [5:0] rw_gap   = cfg_r[`CBSC_POS_RWG +: 6];

	// Configuration outputs come straight from the held image.
	assign io32_mode_en         = cfg_r[`CBSC_POS_IO32]; //RULE6
	assign ext_cache_ratio_bit  = cfg_r[`CBSC_POS_RATIO];
	assign offset_fill_en       = cfg_r[`CBSC_POS_SKEW];
	assign clean_evict_out_en   = cfg_r[`CBSC_POS_CLEAN];
	assign sys_addr_width_sel   = cfg_r[`CBSC_POS_ASIZE +: 2]; //RULE11
	assign sys_bus_layout_sel   = cfg_r[`CBSC_POS_FMT]; //RULE11
	assign sys_clock_multiplier = cfg_r[`CBSC_POS_SCLK +: 4];
	assign shadow_tag_en        = cfg_r[`CBSC_POS_DTAG]; //RULE13
	assign snoop_tag_only_en    = cfg_r[`CBSC_POS_PTAG]; //RULE13
	assign fast_move_dis        = cfg_r[`CBSC_POS_FDIS]; //RULE14
	assign read_evict_cmd_en    = cfg_r[`CBSC_POS_RVIC]; //RULE15
	assign cache_bank_mode_en   = cfg_r[`CBSC_POS_BANK];
	assign sys_evict_ceiling    = cfg_r[`CBSC_POS_VICL +: 3]; //RULE22

	// Serial load: new bits enter at position 0 so the first bit ends highest.
	always @* begin
		shift     = selftest_done & boot_bit_valid & ~config_ready; //RULE1 //RULE21
		chain_nxt = {chain_r[`CBSC_CHAIN_LEN-2:0], boot_bit}; //RULE1
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chain_r           <= {`CBSC_CHAIN_LEN{1'b0}};
			bit_cnt_r         <= 9'h000;
			chain_spill       <= 1'b0;
			chain_spill_valid <= 1'b0;
		end else begin
			chain_spill_valid <= shift;
			if (shift) begin
				chain_r     <= chain_nxt;
				bit_cnt_r   <= bit_cnt_r + 9'h001;
				chain_spill <= chain_r[`CBSC_CHAIN_LEN-1]; //RULE1
			end
		end
	end

	// Capture the low 44 positions on the last bit; higher positions are not kept.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r        <= {`CBSC_IMG_W{1'b0}};
			config_ready <= 1'b0;
			dup_bad_r    <= 1'b0;
			clk_bad_r    <= 1'b0;
		end else if (shift && bit_cnt_r == `CBSC_CHAIN_LAST) begin
			cfg_r        <= chain_nxt[`CBSC_IMG_W-1:0]; //RULE2 //RULE21
			config_ready <= 1'b1;
			dup_bad_r    <= (chain_nxt[`CBSC_POS_CLEAN2] != chain_nxt[`CBSC_POS_CLEAN]) |
				(chain_nxt[`CBSC_POS_CLEAN3] != chain_nxt[`CBSC_POS_CLEAN]); //RULE3
			case (chain_nxt[`CBSC_POS_SCLK +: 4]) //RULE12
			4'h1, 4'h2, 4'h4, 4'h8: clk_bad_r <= 1'b0;
			default: clk_bad_r <= 1'b1;
			endcase
		end
	end

	// Acknowledge counting toward the programmed limit.
	always @* begin
		cnt_inc   = sys_cmd_issue & ~(sys_cmd_read_evict & rv_hold); //RULE16
		outst_nxt = outst_r;
		if (cnt_inc && !sys_ack_in && outst_r != 5'h1F)
			outst_nxt = outst_r + 5'h01;
		else if (!cnt_inc && sys_ack_in && outst_r != 5'h00)
			outst_nxt = outst_r - 5'h01;
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			outst_r       <= 5'h00;
			sys_cmd_stall <= 1'b0;
			mb_forward    <= 1'b0;
			mb_local_done <= 1'b0;
		end else begin
			outst_r       <= outst_nxt;
			sys_cmd_stall <= (ack_lim != 5'h00) & (outst_nxt >= ack_lim); //RULE22
			mb_forward    <= mb_req & mb_en; //RULE22
			mb_local_done <= mb_req & ~mb_en;
		end
	end

	cbsc_evict_accum u_evict (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.victim_push  (victim_push),
		.victim_clean (victim_clean),
		.clean_out_en (clean_evict_out_en),
		.threshold    (thr),
		.flush        (flush_r),
		.stream_start (evict_stream_start),
		.evict_full   (evict_full),
		.victim_count (victim_count)
	); //RULE9

	cbsc_gap_timer u_gap (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.rd_req  (bc_rd_req),
		.wr_req  (bc_wr_req),
		.hold    (ctrl_r[`CBSC_CTRL_HOLD]),
		.ww_gap  (cfg_r[`CBSC_POS_WWG]),
		.rw_gap  (rw_gap),
		.rr_gap  (cfg_r[`CBSC_POS_RRG]),
		.bank_en (cache_bank_mode_en),
		.rd_go   (bc_rd_go),
		.wr_go   (bc_wr_go)
	); //RULE17 //RULE18 //RULE19 //RULE20

	// APB slave: data and answer are prepared in the setup cycle.
	always @* begin
		rd_setup = psel & ~penable;
		wr_acc   = psel & penable & pwrite & pready;
		hit      = 1'b1;
		rd_val   = 32'h00000000;
		case (paddr)
		`CBSC_OFF_STATUS: rd_val = {11'h000, outst_r, 9'h000, victim_count,
			1'b0, clk_bad_r, dup_bad_r, config_ready};
		`CBSC_OFF_CFG_LO: rd_val = cfg_r[31:0];
		`CBSC_OFF_CFG_HI: rd_val = {20'h00000, cfg_r[`CBSC_IMG_W-1:32]};
		`CBSC_OFF_CTRL:   rd_val = {30'h00000000, ctrl_r};
		default:          hit = 1'b0;
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			ctrl_r  <= `CBSC_CTRL_RST;
			flush_r <= 1'b0;
		end else begin
			pready  <= rd_setup;
			pslverr <= rd_setup & ~hit;
			if (rd_setup)
				prdata <= pwrite ? 32'h00000000 : rd_val;
			flush_r <= 1'b0;
			if (wr_acc && paddr == `CBSC_OFF_CTRL) begin
				ctrl_r[`CBSC_CTRL_HOLD] <= pwdata[`CBSC_CTRL_HOLD];
				flush_r <= pwdata[`CBSC_CTRL_FLUSH];
			end
		end
	end
endmodule

/* File: tb/cbsc_config_chain_monitor.sv */
// Assertion checker for the boot configuration chain top module.
// Sees only top module ports; bound from the testbench top file.
`timescale 1ns/1ps
module cbsc_config_chain_monitor (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       selftest_done,
	input wire logic       boot_bit_valid,
	input wire logic       chain_spill_valid,
	input wire logic       config_ready,
	input wire logic       bc_rd_go,
	input wire logic       bc_wr_go,
	input wire logic       mb_req,
	input wire logic       mb_forward,
	input wire logic       mb_local_done,
	input wire logic [3:0] sys_clock_multiplier,
	input wire logic [2:0] sys_evict_ceiling
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_spill; selftest_done && boot_bit_valid && !config_ready |=> chain_spill_valid; endproperty
	a_spill: assert property (p_spill) else $error("spill pulse missing");
	property p_no_extra; config_ready |=> !chain_spill_valid; endproperty
	a_no_extra: assert property (p_no_extra) else $error("surplus bit taken");
	property p_ready_hold; config_ready |=> config_ready; endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
	property p_cfg_fixed; config_ready |=> $stable(sys_clock_multiplier) && $stable(sys_evict_ceiling); endproperty
	a_cfg_fixed: assert property (p_cfg_fixed) else $error("settings changed");
	property p_cfg_zero; !config_ready |-> sys_clock_multiplier == 4'h0 && sys_evict_ceiling == 3'h0; endproperty
	a_cfg_zero: assert property (p_cfg_zero) else $error("settings before load");
	property p_grant_one; bc_rd_go |-> !bc_wr_go; endproperty
	a_grant_one: assert property (p_grant_one) else $error("two grants at once");
	property p_wr_once; bc_wr_go |=> !bc_wr_go; endproperty
	a_wr_once: assert property (p_wr_once) else $error("write granted twice");
	property p_rd_once; bc_rd_go |=> !bc_rd_go; endproperty
	a_rd_once: assert property (p_rd_once) else $error("read granted twice");
	property p_mb; mb_req |=> mb_forward != mb_local_done; endproperty
	a_mb: assert property (p_mb) else $error("barrier not handled");
	property p_mb_cause; mb_forward |-> $past(mb_req); endproperty
	a_mb_cause: assert property (p_mb_cause) else $error("barrier without request");
endmodule

/* File: tb/cbsc_boot_rom_model.sv */
// Serial boot ROM model: sends the chain image MSB first, then surplus bits.
// Assumes the chain samples one bit per mclk cycle while valid is high.
`timescale 1ns/1ps
module cbsc_boot_rom_model #(
	parameter int EXTRA = 3
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic         slow,
	input  wire logic [366:0] image,
	output logic              bit_valid,
	output logic              bit_out
);
	int cnt;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			bit_valid <= 1'h0;
			bit_out <= 1'h0;
		end else if (start && cnt < 367 + EXTRA && !(slow && bit_valid)) begin
			bit_valid <= 1'h1;
			bit_out <= (cnt < 367) ? image[366 - cnt] : ~bit_out;
			cnt <= cnt + 1;
		end else begin
			bit_valid <= 1'h0;
			bit_out <= ~bit_out;
		end
	end
endmodule

/* File: tb/cbsc_config_chain_tb.sv */
// Self-checking bench for the boot configuration chain.
// Assumes a 10 MHz mclk; the boot ROM model feeds the chain after self-test.
`timescale 1ns/1ps
`include "cbsc_regs.vh"
module cbsc_config_chain_tb;
	logic         mclk, rst_n, psel, penable, pwrite, pready, pslverr, selftest_done;
	logic         boot_bit_valid, boot_bit, chain_spill, chain_spill_valid, config_ready;
	logic         victim_push, victim_clean, evict_stream_start, evict_full, rd_e;
	logic         bc_rd_req, bc_wr_req, bc_rd_go, bc_wr_go, sys_cmd_issue, sys_cmd_read_evict;
	logic         sys_ack_in, sys_cmd_stall, mb_req, mb_forward, mb_local_done, io32_mode_en;
	logic         ext_cache_ratio_bit, offset_fill_en, clean_evict_out_en, sys_bus_layout_sel;
	logic         shadow_tag_en, snoop_tag_only_en, fast_move_dis, read_evict_cmd_en;
	logic         cache_bank_mode_en, rom_slow;
	logic [1:0]   sys_addr_width_sel;
	logic [2:0]   sys_evict_ceiling;
	logic [3:0]   sys_clock_multiplier;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd_q;
	logic [366:0] img;
	int           fail_count, compares, cycles, spills, streams, d;

	cbsc_config_chain dut (.*);
	cbsc_boot_rom_model rom (.mclk, .rst_n, .start(selftest_done), .slow(rom_slow),
		.image(img), .bit_valid(boot_bit_valid), .bit_out(boot_bit));

	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		spills <= spills + (chain_spill_valid === 1'h1);
		streams <= streams + (evict_stream_start === 1'h1);
		if (cycles == 3000) begin
			fail_count++;
			final_report;
		end
	end

	task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rd_q = prdata;
		rd_e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task t_load;
		chk("early", {config_ready, sys_clock_multiplier}, 5'h00);
		@(posedge mclk);
		selftest_done <= 1'h1;
		do @(posedge mclk); while (config_ready !== 1'h1);
		chk("io32", io32_mode_en, img[`CBSC_POS_IO32]);
		chk("ratio", ext_cache_ratio_bit, img[`CBSC_POS_RATIO]);
		chk("fill", offset_fill_en, img[`CBSC_POS_SKEW]);
		chk("clean", clean_evict_out_en, img[`CBSC_POS_CLEAN]);
		chk("width", sys_addr_width_sel, img[`CBSC_POS_ASIZE+:2]);
		chk("layout", sys_bus_layout_sel, img[`CBSC_POS_FMT]);
		chk("mult", sys_clock_multiplier, img[`CBSC_POS_SCLK+:4]);
		chk("tags", {shadow_tag_en, snoop_tag_only_en}, {img[`CBSC_POS_DTAG], img[`CBSC_POS_PTAG]});
		chk("fast", fast_move_dis, img[`CBSC_POS_FDIS]);
		chk("rdev", read_evict_cmd_en, img[`CBSC_POS_RVIC]);
		chk("bank", cache_bank_mode_en, img[`CBSC_POS_BANK]);
		chk("ceiling", sys_evict_ceiling, img[`CBSC_POS_VICL+:3]);
		repeat (20) @(posedge mclk);
		chk("spills", spills, 367);
		chk("spill_bit", chain_spill, 1'h0);
		apb(1'h0, `CBSC_OFF_CFG_LO, 32'h0);
		chk("cfg_lo", rd_q, img[31:0]);
		apb(1'h1, `CBSC_OFF_CFG_LO, 32'h0);
		apb(1'h0, `CBSC_OFF_CFG_LO, 32'h0);
		chk("cfg_kept", rd_q, img[31:0]);
		apb(1'h0, `CBSC_OFF_CFG_HI, 32'h0);
		chk("cfg_hi", rd_q, {20'h0, img[43:32]});
		apb(1'h0, `CBSC_OFF_STATUS, 32'h0);
		chk("status", rd_q[2:0], 3'h1);
		apb(1'h0, 12'h010, 32'h0);
		chk("unmapped", rd_e, 1'h1);
		$display("test load done");
	endtask
	task push(input logic c);
		@(posedge mclk);
		victim_push <= 1'h1;
		victim_clean <= c;
		@(posedge mclk);
		victim_push <= 1'h0;
	endtask
	task t_victims;
		push(1'h1);
		push(1'h0);
		apb(1'h0, `CBSC_OFF_STATUS, 32'h0);
		chk("held", {streams[3:0], rd_q[6:4]}, 7'h02);
		push(1'h0);
		repeat (3) @(posedge mclk);
		chk("streams", streams, 1);
		$display("test victims done");
	endtask
	task gdist(input logic r1, input logic r2);
		@(posedge mclk);
		if (r1) bc_rd_req <= 1'h1;
		else bc_wr_req <= 1'h1;
		do @(posedge mclk); while (bc_rd_go !== 1'h1 && bc_wr_go !== 1'h1);
		bc_rd_req <= 1'h0;
		bc_wr_req <= 1'h0;
		@(posedge mclk);
		d = 1;
		if (r2) bc_rd_req <= 1'h1;
		else bc_wr_req <= 1'h1;
		do begin
			@(posedge mclk);
			d++;
		end while ((r2 ? bc_rd_go : bc_wr_go) !== 1'h1);
		bc_rd_req <= 1'h0;
		bc_wr_req <= 1'h0;
	endtask
	task t_gaps;
		gdist(1'h1, 1'h0);
		chk("rd_wr", d, img[`CBSC_POS_RWG+:6] + 1);
		// Two edges of handshake already separate a grant from the next request.
		gdist(1'h0, 1'h0);
		chk("wr_wr", d, 3);
		gdist(1'h1, 1'h1);
		chk("rd_rd", d, 3);
		$display("test gaps done");
	endtask
	task t_bus;
		@(posedge mclk);
		sys_cmd_issue <= 1'h1;
		@(posedge mclk);
		sys_cmd_read_evict <= 1'h1;
		@(posedge mclk);
		sys_cmd_issue <= 1'h0;
		repeat (2) @(posedge mclk);
		chk("stall", sys_cmd_stall, 1'h1);
		sys_ack_in <= 1'h1;
		mb_req <= 1'h1;
		@(posedge mclk);
		sys_ack_in <= 1'h0;
		mb_req <= 1'h0;
		@(posedge mclk);
		chk("forward", mb_forward, img[`CBSC_POS_MB]);
		chk("local", mb_local_done, !img[`CBSC_POS_MB]);
		@(posedge mclk);
		chk("unstall", sys_cmd_stall, 1'h0);
		$display("test bus done");
	endtask
	task t_reload;
		@(posedge mclk);
		rst_n <= 1'h0;
		selftest_done <= 1'h0;
		rom_slow <= 1'h0;
		img <= {img[366:44], 44'hC3A8A6A6007};
		repeat (8) @(posedge mclk);
		chk("in_reset", {config_ready, evict_full, sys_evict_ceiling}, 5'h00);
		rst_n <= 1'h1;
		selftest_done <= 1'h1;
		do @(posedge mclk); while (config_ready !== 1'h1);
		chk("spill_bit2", chain_spill, 1'h0);
		chk("clean_off", clean_evict_out_en, 1'h0);
		push(1'h1);
		repeat (6) push(1'h0);
		@(posedge mclk);
		chk("full", evict_full, 1'h1);
		chk("spills2", spills, 734);
		push(1'h0);
		apb(1'h0, `CBSC_OFF_STATUS, 32'h0);
		chk("six", {streams[3:0], rd_q[6:4]}, 7'h0E);
		apb(1'h1, `CBSC_OFF_CTRL, 32'h1);
		repeat (3) @(posedge mclk);
		chk("flush", {streams[3:0], evict_full}, 5'h04);
		apb(1'h1, `CBSC_OFF_CTRL, 32'h2);
		bc_rd_req <= 1'h1;
		repeat (4) @(posedge mclk);
		chk("hold", bc_rd_go, 1'h0);
		apb(1'h1, `CBSC_OFF_CTRL, 32'h0);
		do @(posedge mclk); while (bc_rd_go !== 1'h1);
		bc_rd_req <= 1'h0;
		chk("unhold", bc_rd_go, 1'h1);
		$display("test reload done");
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		{rst_n, psel, penable, pwrite, selftest_done, victim_push, victim_clean} = '0;
		{bc_rd_req, bc_wr_req, sys_cmd_issue, sys_cmd_read_evict, sys_ack_in, mb_req} = '0;
		paddr = '0;
		rom_slow = 1'h1;
		pwdata = '0;
		img = {367{1'h1}};
		img[43:0] = 44'hC3E8AEA6847;
		repeat (8) @(posedge mclk);
		rst_n <= 1'h1;
		t_load;
		t_victims;
		t_gaps;
		t_bus;
		t_reload;
		final_report;
	end
endmodule

bind cbsc_config_chain cbsc_config_chain_monitor mon (.*);
